// ---- design/icd_status.sv ----
`timescale 1ns/10ps

// ============================================================================
// Three-stage synchroniser; a change is accepted when stages two and three agree.
module icd_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule : icd_sync3

// ============================================================================
// Debug control and flag registers with APB access and TAP-side event capture.
module icd_status (
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            ce_i,
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [7:0]      paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic [31:0]          prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  input  wire logic            tck_i,
  input  wire logic            tap_tlr_i,
  input  wire logic            tap_done_rst_i,
  input  wire icd_pkg::icd_tap_t tap_i,
  input  wire logic            bg_mode_i,
  input  wire logic            debug_mode_i,
  input  wire logic            prog_en_set_i,
  output logic                 break_enable_o,
  output logic                 timer_run_o,
  output logic                 cmd_valid_o,
  output logic [3:0]           cmd_o,
  output logic                 cmd_return_o,
  output logic [1:0]           xfer_state_o,
  output logic                 boot_utility_o,
  output logic                 irq_o
);
  import icd_pkg::*;

  // ==========================================================================
  // Synchronisers for the TAP clock and its data
  logic     tck_s;
  logic     tck_q;
  logic     tlr_s;
  logic     done_rst_s;
  icd_tap_t tap_s;
  logic     tck_rise;

  icd_sync3 u_sync_tck (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .d_i(tck_i), .q_o(tck_s));
  icd_sync3 u_sync_tlr (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .d_i(tap_tlr_i),
                        .q_o(tlr_s));
  icd_sync3 u_sync_done_rst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
                             .d_i(tap_done_rst_i), .q_o(done_rst_s));

  genvar gi;
  generate
    for (gi = 0; gi < $bits(icd_tap_t); gi++) begin : g_tap_sync
      icd_sync3 u_sync (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .d_i(tap_i[gi]),
                        .q_o(tap_s[gi]));
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tck_q <= 1'b0;
    end else if (ce_i) begin
      tck_q <= tck_s;
    end
  end

  // Link data is taken on the rising TCK edge, when the host holds it stable.
  assign tck_rise = tck_s & ~tck_q;

  // ==========================================================================
  // APB decode
  logic setup_ph;
  logic wr_en;
  logic hit_ctl;
  logic hit_flag;
  logic hit_sts;
  logic hit_msk;
  logic mapped;

  assign setup_ph = psel_i & ~penable_i;
  assign wr_en    = psel_i & penable_i & pwrite_i & ce_i;
  assign hit_ctl  = (paddr_i == ADDR_CONTROL);
  assign hit_flag = (paddr_i == ADDR_FLAG);
  assign hit_sts  = (paddr_i == ADDR_IRQ_STATUS);
  assign hit_msk  = (paddr_i == ADDR_IRQ_MASK);
  assign mapped   = hit_ctl | hit_flag | hit_sts | hit_msk;
  assign pready_o = psel_i & penable_i;

  // ==========================================================================
  // Debug control register
  logic       debug_en;
  logic [3:0] cmd;
  logic       cmd_wr;
  logic       cmd_rsvd;

  assign cmd_wr   = wr_en & hit_ctl;
  assign cmd_rsvd = (pwdata_i[CTL_CMD_MSB:CTL_CMD_LSB] > CMD_LAST_DEF);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      debug_en <= CONTROL_RESET[CTL_DEBUG_EN];
    end else if (cmd_wr && bg_mode_i) begin
      debug_en <= pwdata_i[CTL_DEBUG_EN];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd          <= CONTROL_RESET[CTL_CMD_MSB:CTL_CMD_LSB];
      cmd_o        <= 4'h0;
      cmd_valid_o  <= 1'b0;
      cmd_return_o <= 1'b0;
    end else if (ce_i) begin
      cmd_valid_o  <= cmd_wr & ~cmd_rsvd;
      cmd_return_o <= cmd_wr & (pwdata_i[CTL_CMD_MSB:CTL_CMD_LSB] == CMD_RETURN);
      if (cmd_wr) begin
        cmd   <= pwdata_i[CTL_CMD_MSB:CTL_CMD_LSB];
        cmd_o <= pwdata_i[CTL_CMD_MSB:CTL_CMD_LSB];
      end
    end
  end

  // Background commands stay accepted regardless of the enable; only breaks are gated.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      break_enable_o <= 1'b0;
      timer_run_o    <= 1'b0;
    end else if (ce_i) begin
      break_enable_o <= debug_en;
      timer_run_o    <= ~debug_mode_i;
    end
  end

  // ==========================================================================
  // Debug flag register
  logic       xfer_done;
  logic       prog_en_loc;
  logic       prog_en_jtag;
  logic [1:0] xfer_state;
  logic       flag_wr;
  logic       xfer_set;
  logic       prog_en_rd;

  assign flag_wr    = wr_en & hit_flag;
  assign xfer_set   = tck_rise & tap_s.xfer_end;
  assign prog_en_rd = prog_en_loc | prog_en_jtag;

  // Test-Logic-Reset is a level here, so it clears the flags as a synchronous reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer_done <= FLAG_RESET[FLAG_XFER_DONE];
    end else if (ce_i) begin
      if (tlr_s) begin
        xfer_done <= FLAG_RESET[FLAG_XFER_DONE];
      end else if (xfer_set) begin
        xfer_done <= 1'b1;
      end else if (flag_wr) begin
        xfer_done <= pwdata_i[FLAG_XFER_DONE];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer_state <= 2'h0;
    end else if (ce_i) begin
      if (tlr_s || flag_wr) begin
        xfer_state <= 2'h0;
      end else if (tck_rise) begin
        xfer_state <= tap_s.xfer_state;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_en_loc <= FLAG_RESET[FLAG_PROG_EN];
    end else if (ce_i) begin
      if (tlr_s) begin
        prog_en_loc <= FLAG_RESET[FLAG_PROG_EN];
      end else if (prog_en_set_i) begin
        prog_en_loc <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_en_jtag <= 1'b0;
    end else if (ce_i) begin
      if (tlr_s || done_rst_s) begin
        prog_en_jtag <= 1'b0;
      end else if (tck_rise && tap_s.prog_en_set) begin
        prog_en_jtag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer_state_o   <= 2'h0;
      boot_utility_o <= 1'b0;
    end else if (ce_i) begin
      xfer_state_o   <= xfer_state;
      boot_utility_o <= prog_en_rd;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  logic [IRQ_BITS-1:0] irq_sts;
  logic [IRQ_BITS-1:0] irq_msk;
  logic [IRQ_BITS-1:0] irq_evt;

  assign irq_evt = {cmd_wr & cmd_rsvd, xfer_set};
  assign irq_o   = |(irq_sts & irq_msk);

  // A new event outranks a one-to-clear written in the same cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_sts <= '0;
      irq_msk <= '0;
    end else if (ce_i) begin
      irq_sts <= (irq_sts & ~((wr_en && hit_sts) ? pwdata_i[IRQ_BITS-1:0] : '0)) | irq_evt;
      if (wr_en && hit_msk) begin
        irq_msk <= pwdata_i[IRQ_BITS-1:0];
      end
    end
  end

  // ==========================================================================
  // Read data, latched in the setup phase so the access phase answers at once
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (hit_ctl) begin
      next_rdata[CTL_DEBUG_EN]            = debug_en;
      next_rdata[CTL_REG_BREAK]           = 1'b0;
      next_rdata[CTL_TIMER_EN]            = 1'b0;
      next_rdata[CTL_CMD_MSB:CTL_CMD_LSB] = cmd;
    end else if (hit_flag) begin
      next_rdata[FLAG_XFER_DONE] = xfer_done;
      next_rdata[FLAG_PROG_EN]   = prog_en_rd;
    end else if (hit_sts) begin
      next_rdata[IRQ_BITS-1:0] = irq_sts;
    end else if (hit_msk) begin
      next_rdata[IRQ_BITS-1:0] = irq_msk;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (ce_i && setup_ph) begin
      prdata_o  <= pwrite_i ? 32'h0 : next_rdata;
      pslverr_o <= ~mapped;
    end
  end

  // ==========================================================================
  // Assertions
  a_reg_break_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && setup_ph && !pwrite_i && hit_ctl) |=> !prdata_o[CTL_REG_BREAK])
    else $error("register break enable read as one");

  a_timer_en_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && setup_ph && !pwrite_i && hit_ctl) |=> !prdata_o[CTL_TIMER_EN])
    else $error("timer enabled bit read as one");

  a_timer_stops: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && debug_mode_i) |=> !timer_run_o)
    else $error("timer runs in debug mode");

  a_break_follows: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && cmd_wr && bg_mode_i) |=> ##1 (break_enable_o == $past(pwdata_i[CTL_DEBUG_EN], 2)))
    else $error("break enable does not follow a background write");

  a_dbg_en_locked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!bg_mode_i) |=> $stable(debug_en))
    else $error("debug enable changed outside background mode");

  a_tlr_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && tlr_s) |=> (!xfer_done && !prog_en_loc && !prog_en_jtag && xfer_state == 2'h0))
    else $error("test logic reset left a flag set");

  a_xfer_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && xfer_set && !tlr_s) |=> xfer_done)
    else $error("transfer end did not set the flag");

  a_state_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && flag_wr) |=> (xfer_state == 2'h0) ##1 (xfer_state_o == 2'h0))
    else $error("flag write did not clear transfer state");

  a_prog_en_or: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && setup_ph && !pwrite_i && hit_flag)
      |=> (prdata_o[FLAG_PROG_EN] == $past(prog_en_loc | prog_en_jtag)))
    else $error("program enable read is not the OR of both flags");

  a_boot_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> (boot_utility_o == $past(prog_en_rd)))
    else $error("boot select does not follow program enable");

  a_prog_en_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (prog_en_loc && !tlr_s) |=> prog_en_loc)
    else $error("program enable cleared without a reset");

  a_done_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && done_rst_s) |=> !prog_en_jtag)
    else $error("reset on done left the jtag program enable set");

  a_rsvd_noop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && cmd_wr && cmd_rsvd) |=> (!cmd_valid_o && !cmd_return_o))
    else $error("reserved command produced an operation");

endmodule : icd_status

// ---- design/icd_pkg.sv ----
package icd_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_FLAG       = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0C;

  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] FLAG_RESET      = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CTL_CMD_LSB    = 0;
  localparam int CTL_CMD_MSB    = 3;
  localparam int CTL_REG_BREAK  = 5;
  localparam int CTL_TIMER_EN   = 6;
  localparam int CTL_DEBUG_EN   = 7;
  localparam int FLAG_XFER_DONE = 0;
  localparam int FLAG_PROG_EN   = 1;
  localparam int IRQ_XFER       = 0;
  localparam int IRQ_RESERVED   = 1;
  localparam int IRQ_BITS       = 2;

  // ==========================================================================
  // Command codes
  localparam logic [3:0] CMD_RETURN   = 4'h7;
  localparam logic [3:0] CMD_LAST_DEF = 4'hA;

  // ==========================================================================
  // Link side inputs, all from the TAP clock domain
  typedef struct packed {
    logic       xfer_end;
    logic       prog_en_set;
    logic [1:0] xfer_state;
  } icd_tap_t;

endpackage : icd_pkg

// ---- bench/icd_tap_host.sv ----
`timescale 1ns/10ps

// ============================================================================
// Debug host behind the TAP. It drives link frames off its own timebase.
module icd_tap_host (
  output logic              tck_o,
  output logic              tlr_o,
  output logic              done_rst_o,
  output icd_pkg::icd_tap_t tap_o
);
  import icd_pkg::*;

  initial begin
    tck_o = 1'b0;
    tlr_o = 1'b0;
    done_rst_o = 1'b0;
    tap_o = '0;
  end

  // Data is held four clock cycles before the rising edge and five clock cycles after it.
  // The clock stands still between frames, and the released data toggles.
  task automatic frame(input logic e, input logic p, input logic [1:0] s);
    #7;
    tap_o = '{xfer_end: e, prog_en_set: p, xfer_state: s};
    #80;
    tck_o = 1'b1;
    #80;
    tck_o = 1'b0;
    #20;
    tap_o = ~tap_o;
  endtask : frame

  task automatic test_reset();
    #5;
    tlr_o = 1'b1;
    #200;
    tlr_o = 1'b0;
  endtask : test_reset

  task automatic set_done_rst(input logic v);
    #5;
    done_rst_o = v;
  endtask : set_done_rst
endmodule : icd_tap_host

// ---- bench/icd_status_tb_top.sv ----
`timescale 1ns/10ps

// ============================================================================
// Register and link checks through APB and the host model.
module icd_status_tb_top;
  import icd_pkg::*;
  logic        clk_i, rst_b_i, psel, penable, pwrite, bg, dbg, pset;
  logic        pready_o, pslverr_o, brk_o, tmr_o, val_o, ret_o, boot_o, irq_o;
  logic        tck, tlr, done_rst, err, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_o, q;
  logic [3:0]  cmd_o;
  logic [1:0]  xst_o;
  icd_tap_t    tap;
  int          n_mismatch, n_compared, n_ret, n_val;

  icd_tap_host i_icd_tap_host (.tck_o(tck), .tlr_o(tlr), .done_rst_o(done_rst), .tap_o(tap));
  icd_status i_icd_status (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tck_i(tck),
    .tap_tlr_i(tlr), .tap_done_rst_i(done_rst), .tap_i(tap), .bg_mode_i(bg),
    .debug_mode_i(dbg),
    .prog_en_set_i(pset), .break_enable_o(brk_o), .timer_run_o(tmr_o),
    .cmd_valid_o(val_o), .cmd_o(cmd_o), .cmd_return_o(ret_o), .xfer_state_o(xst_o),
    .boot_utility_o(boot_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Strobes are counted on the falling edge, away from the edge that launches them.
  always @(negedge clk_i) begin
    n_ret += int'(ret_o === 1'b1);
    n_val += int'(val_o === 1'b1);
  end

  task automatic end_sim();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    q   = prdata_o;
    err = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      end_sim();
    end
  endtask : apb

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask : rd

  initial begin
    {psel, penable, pwrite, bg, dbg, pset} = '0;
    ce      = 1'b1;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd("control", ADDR_CONTROL, 32'h0);
    rd("flag", ADDR_FLAG, 32'h0);
    $display("test reset done");
    bg <= 1'b1;
    apb(1'b1, ADDR_CONTROL, 32'hFF);
    rd("control", ADDR_CONTROL, 32'h8F);
    check("break enable", brk_o, 1'b1);
    rd("irq status", ADDR_IRQ_STATUS, 32'h2);
    check("cmd valid", n_val, 0);
    bg <= 1'b0;
    apb(1'b1, ADDR_CONTROL, 32'h07);
    rd("control", ADDR_CONTROL, 32'h87);
    check("cmd", cmd_o, 32'h7);
    check("cmd return", n_ret, 1);
    check("cmd valid", n_val, 1);
    bg <= 1'b1;
    apb(1'b1, ADDR_CONTROL, 32'h00);
    rd("control", ADDR_CONTROL, 32'h0);
    check("break enable", brk_o, 1'b0);
    check("timer run", tmr_o, 1'b1);
    dbg <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("timer run", tmr_o, 1'b0);
    $display("test control done");
    ce <= 1'b0;
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    ce <= 1'b1;
    rd("irq mask", ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    #1 check("irq", irq_o, 1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h2);
    #1 check("irq", irq_o, 1'b0);
    i_icd_tap_host.frame(1'b0, 1'b0, 2'b01);
    rd("flag", ADDR_FLAG, 32'h0);
    check("xfer state", xst_o, 2'b01);
    i_icd_tap_host.frame(1'b1, 1'b1, 2'b10);
    rd("flag", ADDR_FLAG, 32'h3);
    check("boot utility", boot_o, 1'b1);
    check("irq", irq_o, 1'b1);
    apb(1'b1, ADDR_FLAG, 32'hFC);
    rd("flag", ADDR_FLAG, 32'h2);
    check("xfer state", xst_o, 2'b00);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    #1 check("irq", irq_o, 1'b0);
    $display("test link done");
    i_icd_tap_host.set_done_rst(1'b1);
    repeat (8) @(posedge clk_i);
    rd("flag", ADDR_FLAG, 32'h0);
    check("boot utility", boot_o, 1'b0);
    apb(1'b1, ADDR_FLAG, 32'hFE);
    rd("flag", ADDR_FLAG, 32'h0);
    i_icd_tap_host.set_done_rst(1'b0);
    @(posedge clk_i);
    pset <= 1'b1;
    @(posedge clk_i);
    pset <= 1'b0;
    apb(1'b1, ADDR_FLAG, 32'h1);
    rd("flag", ADDR_FLAG, 32'h3);
    i_icd_tap_host.test_reset();
    rd("flag", ADDR_FLAG, 32'h0);
    rd("unmapped", 8'h10, 32'h0);
    check("slave error", err, 1'b1);
    $display("test flag done");
    end_sim();
  end

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule : icd_status_tb_top
